// file: hdl/dmds_pkg.sv
package dmds_pkg;

  // ****************************************************
  // datapath geometry
  // ****************************************************
  localparam int ACC_W     = 40;
  localparam int LOW_W     = 16;
  localparam int HIGH_W    = 24;
  localparam int GUARD_W   = 8;
  localparam int VAL_W     = 16;
  localparam int NUM_ACC   = 4;
  localparam int SEL_W     = 2;
  localparam int DEC_W     = 16;
  localparam int DEC_INS   = 15;

  localparam logic [LOW_W-1:0]  LOW_SAT_POS  = 16'h7fff;
  localparam logic [LOW_W-1:0]  LOW_SAT_NEG  = 16'h8000;
  localparam logic [HIGH_W-1:0] HIGH_SAT_POS = 24'h007fff;
  localparam logic [HIGH_W-1:0] HIGH_SAT_NEG = 24'hff8000;

  // ****************************************************
  // instruction word layout
  // ****************************************************
  localparam int              OPC_W       = 24;
  localparam int              FIX_HI      = 23;
  localparam int              FIX_LO      = 17;
  localparam logic [6:0]      FIX_VAL     = 7'h08;
  localparam int              PAR_BIT     = 16;
  localparam int              W_SEL_HI    = 15;
  localparam int              X_SEL_HI    = 13;
  localparam int              KEY_HI      = 11;
  localparam int              KEY_LO      = 8;
  localparam logic [3:0]      KEY_VAL     = 4'hc;
  localparam int              Y_SEL_HI    = 7;
  localparam int              Z_SEL_HI    = 5;

  // ****************************************************
  // register map
  // ****************************************************
  localparam int              ADDR_W      = 8;
  localparam logic [7:0]      CTRL_OFS    = 8'h00;
  localparam logic [7:0]      STAT_OFS    = 8'h04;
  localparam logic [7:0]      DEC_OFS     = 8'h08;
  localparam logic [7:0]      ACC_BASE    = 8'h10;
  localparam logic [7:0]      ACC_END     = 8'h2c;
  localparam int              CTRL_SAT    = 0;
  localparam int              CTRL_LEG    = 1;
  localparam int              STAT_CARRY  = 4;
  localparam logic [31:0]     CTRL_RST    = 32'h0000_0000;

  typedef struct packed {
    logic             valid;
    logic [OPC_W-1:0] opc;
  } dmds_instr_s;

  typedef struct packed {
    logic             match;
    logic             parallel;
    logic [SEL_W-1:0] xSel;
    logic [SEL_W-1:0] ySel;
    logic [SEL_W-1:0] zSel;
    logic [SEL_W-1:0] wSel;
  } dmds_fields_s;

endpackage

// file: hdl/dmds_decoder.sv
`timescale 1ns/1ps
module dmds_decoder (
  input  wire dmds_pkg::dmds_instr_s instr,
  output dmds_pkg::dmds_fields_s fields
);
  import dmds_pkg::*;

  function automatic logic [SEL_W-1:0] selAt(input logic [OPC_W-1:0] w, input int hi);
    selAt = w[hi -: SEL_W];
  endfunction

  wire fixOk = instr.opc[FIX_HI:FIX_LO] == FIX_VAL;
  wire keyOk = instr.opc[KEY_HI:KEY_LO] == KEY_VAL;

  assign fields.match    = fixOk & keyOk;
  assign fields.parallel = instr.opc[PAR_BIT];
  assign fields.wSel     = selAt(instr.opc, W_SEL_HI);
  assign fields.xSel     = selAt(instr.opc, X_SEL_HI);
  assign fields.ySel     = selAt(instr.opc, Y_SEL_HI);
  assign fields.zSel     = selAt(instr.opc, Z_SEL_HI);

endmodule

// file: hdl/dmds_path_alu.sv
`timescale 1ns/1ps
module dmds_path_alu #(
  parameter int           W       = 16,
  parameter int           VW      = 16,
  parameter logic [W-1:0] SAT_POS = '0,
  parameter logic [W-1:0] SAT_NEG = '0
) (
  input  wire logic [W-1:0] x,
  input  wire logic [W-1:0] y,
  input  wire logic         satOn,
  input  wire logic         ovfOn,
  output logic      [W-1:0] diff,
  output logic              ovf,
  output logic              carry,
  output logic      [W-1:0] maxVal,
  output logic              decision
);
  // ****************************************************
  // subtract with one extra bit so true sign survives
  // ****************************************************
  logic [W:0]      rawDiff;
  logic [W-VW+1:0] topBits;
  logic            ovfRaw;
  logic            firstGreater;

  assign rawDiff = {y[W-1], y} - {x[W-1], x};
  // bits above the value sign must all copy it
  assign topBits = rawDiff[W:VW-1];
  assign ovfRaw  = !((&topBits) || (~|topBits));
  assign ovf     = ovfRaw & ovfOn;
  assign diff    = (ovf & satOn) ? (rawDiff[W] ? SAT_NEG : SAT_POS)
                                 : rawDiff[W-1:0];
  // no borrow out of the value field
  assign carry   = y[VW-1:0] >= x[VW-1:0];

  assign firstGreater = $signed(x[VW-1:0]) > $signed(y[VW-1:0]);
  assign maxVal   = firstGreater ? x : y;
  assign decision = ~firstGreater;

endmodule

// file: hdl/dmds_top.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module dmds_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire dmds_pkg::dmds_instr_s instr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       instrDone,
  output logic                       instrIllegal,
  output logic                       carryFlag,
  output logic      [3:0]            overflowFlags,
  output logic      [15:0]           highPathDecision,
  output logic      [15:0]           lowPathDecision
);
  import dmds_pkg::*;

  // ****************************************************
  // helpers
  // ****************************************************
  // one compare shared by instruction and bus selectors
  function automatic logic selHit(input logic [SEL_W-1:0] sel, input int idx);
    selHit = (sel == SEL_W'(idx));
  endfunction

  // ****************************************************
  // state
  // ****************************************************
  logic [ACC_W-1:0]   acc_q [NUM_ACC];
  logic [ACC_W-1:0]   acc_d [NUM_ACC];
  logic [NUM_ACC-1:0] ovf_q;
  logic [NUM_ACC-1:0] ovf_d;
  logic               carry_q;
  logic               carry_d;
  logic [DEC_W-1:0]   hiDec_q;
  logic [DEC_W-1:0]   hiDec_d;
  logic [DEC_W-1:0]   loDec_q;
  logic [DEC_W-1:0]   loDec_d;
  logic               satEn_q;
  logic               legacy_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  logic               done_q;
  logic               illegal_q;

  // ****************************************************
  // instruction decode
  // ****************************************************
  dmds_fields_s fields;

  dmds_decoder u_dec (
    .instr  (instr),
    .fields (fields)
  );

  // accepted every cycle, so repeats run back to back
  wire exec    = instr.valid & fields.match;
  wire illegal = instr.valid & ~fields.match;

  // ****************************************************
  // source sampling
  // ****************************************************
  // both sources read from the old register contents
  wire [ACC_W-1:0] srcX = acc_q[fields.xSel];
  wire [ACC_W-1:0] srcY = acc_q[fields.ySel];

  // ****************************************************
  // mode gating
  // ****************************************************
  // legacy mode masks saturation and low overflow
  wire satOn   = satEn_q & ~legacy_q;
  // high overflow is reported in every mode
  wire loOvfOn = ~legacy_q;

  // ****************************************************
  // split datapaths
  // ****************************************************
  logic [HIGH_W-1:0] hiDiff;
  logic [HIGH_W-1:0] hiMax;
  logic              hiOvf;
  logic              hiCarry;
  logic              hiPick;
  logic [LOW_W-1:0]  loDiff;
  logic [LOW_W-1:0]  loMax;
  logic              loOvf;
  logic              loPick;

  // guard bits ride with the high path
  dmds_path_alu #(
    .W       (HIGH_W),
    .VW      (VAL_W),
    .SAT_POS (HIGH_SAT_POS),
    .SAT_NEG (HIGH_SAT_NEG)
  ) u_high (
    .x        (srcX[ACC_W-1:LOW_W]),
    .y        (srcY[ACC_W-1:LOW_W]),
    .satOn    (satOn),
    .ovfOn    (1'b1),
    .diff     (hiDiff),
    .ovf      (hiOvf),
    .carry    (hiCarry),
    .maxVal   (hiMax),
    .decision (hiPick)
  );

  // low carry is never reported, so it is left open
  dmds_path_alu #(
    .W       (LOW_W),
    .VW      (VAL_W),
    .SAT_POS (LOW_SAT_POS),
    .SAT_NEG (LOW_SAT_NEG)
  ) u_low (
    .x        (srcX[LOW_W-1:0]),
    .y        (srcY[LOW_W-1:0]),
    .satOn    (satOn),
    .ovfOn    (loOvfOn),
    .diff     (loDiff),
    .ovf      (loOvf),
    .carry    (),
    .maxVal   (loMax),
    .decision (loPick)
  );

  wire [ACC_W-1:0] diffWord = {hiDiff, loDiff};
  wire [ACC_W-1:0] maxWord  = {hiMax, loMax};
  wire             anyOvf   = hiOvf | loOvf;

  // ****************************************************
  // apb decode
  // ****************************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire aligned = paddr[1:0] == 2'b00;
  wire isCtrl  = aligned & (paddr == CTRL_OFS);
  wire isStat  = aligned & (paddr == STAT_OFS);
  wire isDec   = aligned & (paddr == DEC_OFS);
  wire isAcc   = aligned & (paddr >= ACC_BASE) & (paddr <= ACC_END);
  wire mapped  = isCtrl | isStat | isDec | isAcc;
  // each accumulator takes two words: value bits, then guard
  wire [ADDR_W-1:0] accOfs  = paddr - ACC_BASE;
  wire [SEL_W-1:0]  accIdx  = accOfs[4:3];
  wire              accHigh = paddr[2];

  wire wrEn   = access & pwrite & mapped;
  wire wrCtrl = wrEn & isCtrl;
  wire wrStat = wrEn & isStat;
  wire wrDec  = wrEn & isDec;
  wire wrAcc  = wrEn & isAcc;

  wire [ACC_W-1:0] rdAcc = acc_q[accIdx];

  wire [31:0] ctrlWord = {30'h0000_0000, legacy_q, satEn_q};
  wire [31:0] statWord = {27'h000_0000, carry_q, ovf_q};
  wire [31:0] decWord  = {hiDec_q, loDec_q};
  wire [31:0] accWord  = accHigh ? {24'h00_0000, rdAcc[ACC_W-1:32]}
                                 : rdAcc[31:0];

  wire [31:0] readMux = isCtrl ? ctrlWord :
                        isStat ? statWord :
                        isDec  ? decWord  :
                        isAcc  ? accWord  : 32'h0000_0000;

  // ****************************************************
  // apb response
  // ****************************************************
  // answers with no wait state; data caught in setup
  // pslverr stays up until the next setup, harmless on apb
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************************
  // accumulator and flag next state
  // ****************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ACC; gi++) begin : g_acc
      wire zHit  = exec & selHit(fields.zSel, gi);
      wire wHit  = exec & selHit(fields.wSel, gi);
      wire swHit = wrAcc & selHit(accIdx, gi);
      wire ovfClr = wrStat & pwdata[gi];

      // extremum overrides difference when both name one register
      assign acc_d[gi] = zHit  ? maxWord :
                         wHit  ? diffWord :
                         (swHit & accHigh) ? {pwdata[GUARD_W-1:0], acc_q[gi][31:0]} :
                         swHit ? {acc_q[gi][ACC_W-1:32], pwdata} :
                                 acc_q[gi];

      // a new overflow beats a software clear in the same cycle
      assign ovf_d[gi] = (wHit & anyOvf) | (ovf_q[gi] & ~ovfClr);
    end
  endgenerate

  // ****************************************************
  // carry and decision shift registers
  // ****************************************************
  // carry ignores the low path entirely
  assign carry_d = exec   ? hiCarry :
                   wrStat ? pwdata[STAT_CARRY] : carry_q;

  assign hiDec_d = exec  ? {hiPick, hiDec_q[DEC_W-1:1]} :
                   wrDec ? pwdata[31:16] : hiDec_q;
  assign loDec_d = exec  ? {loPick, loDec_q[DEC_W-1:1]} :
                   wrDec ? pwdata[15:0] : loDec_q;

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= acc_d[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= '0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
    end
  end

  // both decision registers move on the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      hiDec_q <= '0;
      loDec_q <= '0;
    end else begin
      hiDec_q <= hiDec_d;
      loDec_q <= loDec_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      satEn_q  <= CTRL_RST[CTRL_SAT];
      legacy_q <= CTRL_RST[CTRL_LEG];
    end else if (wrCtrl) begin
      satEn_q  <= pwdata[CTRL_SAT];
      legacy_q <= pwdata[CTRL_LEG];
    end
  end

  // read data and error settle during setup, held through access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : readMux;
      pslverr_q <= ~mapped;
    end
  end

  // ****************************************************
  // instruction status pulses
  // ****************************************************
  // one-cycle pulses; a caller that needs them longer must latch
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q    <= exec;
      illegal_q <= illegal;
    end
  end

  // ****************************************************
  // status outputs
  // ****************************************************
  assign instrDone        = done_q;
  assign instrIllegal     = illegal_q;
  assign carryFlag        = carry_q;
  assign overflowFlags    = ovf_q;
  assign highPathDecision = hiDec_q;
  assign lowPathDecision  = loDec_q;

endmodule

// file: testbench/dmds_asserts.sv
`timescale 1ns/1ps
module dmds_asserts (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire dmds_pkg::dmds_instr_s instr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  instrDone,
  input wire logic                  instrIllegal,
  input wire logic                  carryFlag,
  input wire logic [3:0]            overflowFlags,
  input wire logic [15:0]           highPathDecision,
  input wire logic [15:0]           lowPathDecision
);
  import dmds_pkg::*;
  // ****
  // decode of the observed traffic
  // ****
  logic       take;
  logic       apbWr;
  logic       decWr;
  logic       statWr;
  logic [1:0] wSel;
  assign take = instr.valid && instr.opc[FIX_HI:FIX_LO] == FIX_VAL
                && instr.opc[KEY_HI:KEY_LO] == KEY_VAL;
  assign apbWr = psel && penable && pwrite && pready;
  assign decWr = apbWr && paddr == DEC_OFS;
  assign statWr = apbWr && paddr == STAT_OFS;
  assign wSel = instr.opc[W_SEL_HI:W_SEL_HI-1];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_DONE: assert property (take |=> instrDone && !instrIllegal)
    else $error("done pulse missing");
  AST_NO_DONE: assert property (!take |=> !instrDone)
    else $error("done pulse without instruction");
  AST_ILLEGAL: assert property (instr.valid && !take |=> instrIllegal && !instrDone)
    else $error("illegal opcode not flagged");
  AST_HI_SHIFT: assert property (
    take |=> highPathDecision[14:0] == $past(highPathDecision[15:1]))
    else $error("high decision not shifted");
  AST_LO_SHIFT: assert property (
    take |=> lowPathDecision[14:0] == $past(lowPathDecision[15:1]))
    else $error("low decision not shifted");
  AST_DEC_HOLD: assert property (
    !take && !decWr |=> $stable(highPathDecision) && $stable(lowPathDecision))
    else $error("decision changed without cause");
  AST_OVF_STICKY: assert property (
    !statWr |=> (overflowFlags & $past(overflowFlags)) == $past(overflowFlags))
    else $error("overflow flag lost");
  AST_OVF_DEST: assert property (
    take |=> (overflowFlags & ~$past(overflowFlags) & ~(4'h1 << $past(wSel))) == 4'h0)
    else $error("overflow set on wrong accumulator");
  AST_CARRY_HOLD: assert property (!take && !statWr |=> $stable(carryFlag))
    else $error("carry changed without cause");
endmodule
bind dmds_top dmds_asserts u_chk (.clk(clk), .rst(rst), .instr(instr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .instrDone(instrDone), .instrIllegal(instrIllegal),
  .carryFlag(carryFlag), .overflowFlags(overflowFlags),
  .highPathDecision(highPathDecision), .lowPathDecision(lowPathDecision));

// file: testbench/dmds_cpu_model.sv
`timescale 1ns/1ps
module dmds_cpu_model (
  input  wire logic             clk,
  output dmds_pkg::dmds_instr_s instr
);
  import dmds_pkg::*;
  initial instr = '0;
  // encoding with fixed pattern and selector fields
  function automatic logic [23:0] enc(input logic [1:0] w, x, y, z);
    return {FIX_VAL, 1'b0, w, x, KEY_VAL, y, z, 4'h0};
  endfunction
  // one cycle per instruction; opcode scrambled when idle so stale bits never pass
  task automatic issue(input logic [23:0] opc);
    @(posedge clk);
    instr <= {1'b1, opc};
    @(posedge clk);
    instr <= {1'b0, ~opc};
  endtask
endmodule

// file: testbench/tb_dual_max_diff_select.sv
`timescale 1ns/1ps
module tb_dual_max_diff_select;
  import dmds_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, instrDone, instrIllegal, carryFlag;
  logic [3:0]  overflowFlags;
  logic [15:0] highPathDecision, lowPathDecision;
  dmds_instr_s instr;
  int          mismatches = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  dmds_cpu_model cpu (.clk(clk), .instr(instr));
  dmds_top uut (.clk(clk), .rst(rst), .instr(instr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instrDone(instrDone), .instrIllegal(instrIllegal),
    .carryFlag(carryFlag), .overflowFlags(overflowFlags),
    .highPathDecision(highPathDecision), .lowPathDecision(lowPathDecision));
  // ****
  // shared tasks
  // ****
  task close_out;
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      mismatches++;
      close_out;
    end
  endtask
  task setAcc(input int n, input logic [39:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ACC_BASE + 8'(8 * n), v[31:0], r, e);
    apb(1'b1, ACC_BASE + 8'(8 * n + 4), {24'h0, v[39:32]}, r, e);
  endtask
  task chkAcc(input int n, input logic [39:0] exp);
    logic [31:0] lo, hi;
    logic        e;
    apb(1'b0, ACC_BASE + 8'(8 * n), 32'h0, lo, e);
    apb(1'b0, ACC_BASE + 8'(8 * n + 4), 32'h0, hi, e);
    chk({hi[7:0], lo}, exp);
  endtask
  // ****
  // scenarios
  // ****
  task sc_reset;
    logic [31:0] r;
    logic        e;
    apb(1'b0, CTRL_OFS, 32'h0, r, e);
    chk(r, CTRL_RST);
    apb(1'b1, 8'h40, 32'hffff_ffff, r, e);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0});
    cpu.issue(24'h12_3456);
    #1;
    chk(instrIllegal, 1'b1);
    chk({highPathDecision, lowPathDecision}, 32'h0);
  endtask
  // destination doubles as second source: old value must feed both results
  task sc_example;
    logic [31:0] r;
    logic        e;
    setAcc(0, 40'h10_2400_2222);
    setAcc(1, 40'h90_0000_0000);
    setAcc(2, 40'h0);
    apb(1'b1, DEC_OFS, 32'h1000_0100, r, e);
    apb(1'b1, CTRL_OFS, 32'h1, r, e);
    cpu.issue(cpu.enc(2'd1, 2'd0, 2'd1, 2'd2));
    #1;
    chk(instrDone, 1'b1);
    chk({highPathDecision, lowPathDecision}, 32'h0800_0080);
    chk({carryFlag, overflowFlags}, 5'h02);
    chkAcc(1, 40'hff_8000_ddde);
    chkAcc(2, 40'h10_2400_2222);
  endtask
  task sc_modes;
    logic [122:0] rows [7];
    logic [31:0]  r;
    logic         e, sat, leg, ov, gh, gl;
    logic [39:0]  x, y, d;
    rows = '{{2'b10, 40'h0000008000, 40'h0000007fff, 40'h0000007fff, 1'b1},
             {2'b00, 40'h0000008000, 40'h0000007fff, 40'h000000ffff, 1'b1},
             {2'b11, 40'h0000008000, 40'h0000007fff, 40'h000000ffff, 1'b0},
             {2'b10, 40'h0000007fff, 40'h0000008000, 40'h0000008000, 1'b1},
             {2'b10, 40'h0000000001, 40'h0000000001, 40'h0000000000, 1'b0},
             {2'b10, 40'h8000000000, 40'h0000000000, 40'h007fff0000, 1'b1},
             {2'b11, 40'h8000000000, 40'h0000000000, 40'h8000000000, 1'b1}};
    for (int i = 0; i < 7; i++) begin
      {sat, leg, x, y, d, ov} = rows[i];
      gh = $signed(x[31:16]) > $signed(y[31:16]);
      gl = $signed(x[15:0]) > $signed(y[15:0]);
      apb(1'b1, STAT_OFS, 32'h0000_000f, r, e);
      apb(1'b1, CTRL_OFS, {30'h0, leg, sat}, r, e);
      setAcc(0, x);
      setAcc(2, y);
      cpu.issue(cpu.enc(2'd3, 2'd0, 2'd2, 2'd1));
      #1;
      chk(overflowFlags, {ov, 3'h0});
      chk(carryFlag, y[31:16] >= x[31:16]);
      chk({highPathDecision[15], lowPathDecision[15]}, {!gh, !gl});
      chkAcc(3, d);
      chkAcc(1, {gh ? x[39:16] : y[39:16], gl ? x[15:0] : y[15:0]});
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    sc_reset;
    sc_example;
    sc_modes;
    close_out;
  end
endmodule
